/* File: design/tcw_pkg.sv */
//----------------------------------------------------------------------
// Purpose : Shared constants and types of the tick counter and watchdog
// Assumes : 8-bit registers on a 32-bit classic Wishbone slave
// Notes   : All offsets, fields, reset values and rates are named here
//----------------------------------------------------------------------
package tcw_pkg;

    //------------------------------------------------------------------
    // Register byte addresses
    //------------------------------------------------------------------
    localparam logic [7:0] TCW_ADR_VALUE  = 8'h00; // Counter value
    localparam logic [7:0] TCW_ADR_CTRL   = 8'h04; // Counter control
    localparam logic [7:0] TCW_ADR_WDOG   = 8'h08; // Watchdog control
    localparam logic [7:0] TCW_ADR_STATUS = 8'h0C; // Sticky events, W1C
    localparam logic [7:0] TCW_ADR_MASK   = 8'h10; // Interrupt mask

    //------------------------------------------------------------------
    // Field positions
    //------------------------------------------------------------------
    localparam int TCW_CTL_SRC_BIT  = 5; // Source: 0 internal, 1 pin
    localparam int TCW_CTL_EDGE_BIT = 4; // Edge: 0 rising, 1 falling
    localparam int TCW_CTL_PRESCALER_ASSIGN_ENABLE_BIT = 3; // Prescaler assigned
    localparam int TCW_RATE_MSB     = 2; // Rate field top bit
    localparam int TCW_WD_EN_BIT    = 3; // Watchdog enable
    localparam int TCW_ST_OVF_BIT   = 0; // Counter overflow event
    localparam int TCW_ST_WDT_BIT   = 1; // Watchdog time-out event

    //------------------------------------------------------------------
    // Widths and reset values
    //------------------------------------------------------------------
    localparam int         TCW_CTRL_W     = 6;
    localparam int         TCW_EVT_W      = 2;
    localparam logic [5:0] TCW_CTRL_RESET = 6'h3F; // All ones after reset
    localparam logic [3:0] TCW_WDOG_RESET = 4'h0;
    localparam logic [7:0] TCW_CNT_MAX    = 8'hFF;
    localparam logic [7:0] TCW_CNT_ZERO   = 8'h00;

    //------------------------------------------------------------------
    // Timing
    //------------------------------------------------------------------
    localparam int TCW_CLK_HZ     = 100_000_000; // System clock
    localparam int TCW_INSTR_CLKS = 2;           // Clocks per instruction
    localparam int TCW_SUB_OSC_HZ = 32_768;      // Sub-oscillator rate
    // Clocks per half sub-oscillator tick (Fs/2)
    localparam int TCW_HALF_SUB_CLKS = TCW_CLK_HZ / (TCW_SUB_OSC_HZ / 2);

    //------------------------------------------------------------------
    // Core operating modes
    //------------------------------------------------------------------
    typedef enum logic [1:0] {
        TCW_NORMAL,
        TCW_GREEN,
        TCW_IDLE,
        TCW_SLEEP
    } tcw_mode_e;

    // Mask of prescaler bits that must be all ones for one output tick
    function automatic logic [7:0] tcw_ratio_mask(input logic [2:0] code,
                                                  input logic       dbl);
        logic [8:0] m;
        m = dbl ? (9'h002 << code) : (9'h001 << code);
        return 8'((m - 9'h001));
    endfunction

endpackage

/* File: design/tcw_divider.sv */
//----------------------------------------------------------------------
// Purpose : Enable pulse generator dividing the system clock
// Assumes : One clock domain, synchronous reset
// Notes   : Pulse is one cycle wide, every DIV cycles
//----------------------------------------------------------------------
`timescale 1ns/100ps
module tcw_divider #(
    parameter int DIV = 2 // Clocks between pulses
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Enable pulse
    output logic      tick_o
);
    import tcw_pkg::*;

    // Register state
    typedef struct packed {
        logic [15:0] cnt; // Cycle count within a period
    } tcw_div_s;

    localparam logic [15:0] LAST = 16'(DIV - 1);

    tcw_div_s s_q;
    tcw_div_s s_d;

    // Next state: wrap at the last cycle
    always_comb begin
        s_d = s_q;
        if (s_q.cnt == LAST) begin
            s_d.cnt = 16'h0000;
        end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick_o = (s_q.cnt == LAST);

endmodule

/* File: design/tcw_prescaler.sv */
//----------------------------------------------------------------------
// Purpose : 8-bit prescaler counter with power-of-two ratio select
// Assumes : inc_i is a one-cycle event from the chosen source
// Notes   : tick_o is combinational from count and inc_i
//----------------------------------------------------------------------
`timescale 1ns/100ps
module tcw_prescaler (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Control
    input  wire logic       clear_i,  // Zero the count
    input  wire logic       inc_i,    // Source event
    input  wire logic [2:0] code_i,   // Rate code
    input  wire logic       dbl_i,    // Ratios start at 1:2
    input  wire logic       bypass_i, // Ratio 1:1
    // Results
    output logic            tick_o,   // Divided event
    output logic [7:0]      count_o   // Current count
);
    import tcw_pkg::*;

    // Register state
    typedef struct packed {
        logic [7:0] cnt; // Prescaler count
    } tcw_pre_s;

    tcw_pre_s   s_q;
    tcw_pre_s   s_d;
    logic [7:0] mask;

    // Next state: clear beats counting
    always_comb begin
        s_d = s_q;
        if (clear_i) begin
            s_d.cnt = TCW_CNT_ZERO;
        end else if (inc_i) begin
            s_d.cnt = s_q.cnt + 8'h01;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Output tick once every selected number of events
    assign mask    = tcw_ratio_mask(code_i, dbl_i);
    assign tick_o  = inc_i & (bypass_i | ((s_q.cnt & mask) == mask));
    assign count_o = s_q.cnt;

endmodule

/* File: design/tcw_top.sv */
//----------------------------------------------------------------------
// Purpose : Tick counter and watchdog timer with prescalers
// Assumes : Pin and core strobes synchronous to clk_i
// Notes   : Registers over classic Wishbone, one level interrupt
//----------------------------------------------------------------------
// How it works
// RULE1 - Separate 8-bit prescalers for counter and watchdog
// RULE2 - Each prescaler ratio from its 3-bit rate field
// RULE3 - Writing counter value also zeroes its prescaler
// RULE4 - Watchdog-clear or sleep zeroes watchdog prescaler
// RULE5 - Counter is 8-bit up-counter, readable and writable
// RULE6 - Counter source internal or pin, edge selectable
// RULE7 - Internal, no prescaler: one count per instruction
// RULE8 - Pin source: one count per selected edge
// RULE9 - Watchdog runs free from sub-oscillator, even sleeping
// RULE10 - Enabled watchdog time-out resets device when awake
// RULE11 - Watchdog enable changeable in normal and green
// RULE12 - Time-out equals ratio times 256 half-sub ticks
// RULE13 - Counter ratio 1:1 unassigned, else 1:2 to 1:256
// RULE14 - Watchdog ratios 1:1 to 1:128 from sub-oscillator
// RULE15 - Edge bit: zero rising, one falling
// RULE16 - Pin period must exceed instruction period
// RULE17 - Counter wraps FF to 00 and flags overflow
// RULE18 - Clear and sleep restart the whole watchdog count
//----------------------------------------------------------------------
`timescale 1ns/100ps
module tcw_top #(
    parameter int INSTR_CLKS    = tcw_pkg::TCW_INSTR_CLKS,
    parameter int HALF_SUB_CLKS = tcw_pkg::TCW_HALF_SUB_CLKS
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Core and pin
    input  wire logic              counter_pin_i,
    input  wire tcw_pkg::tcw_mode_e cpu_mode_i,
    input  wire logic              wdt_clear_i,
    input  wire logic              sleep_exec_i,
    // Results
    output logic                   irq_o,
    output logic                   wdt_reset_o
);
    import tcw_pkg::*;

    //------------------------------------------------------------------
    // State
    //------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]           value;    // Counter value
        logic [TCW_CTRL_W-1:0] ctrl;    // Counter control
        logic [3:0]           wdog;     // Watchdog enable and rate
        logic [7:0]           wdt_cnt;  // Watchdog count
        logic [TCW_EVT_W-1:0] status;   // Sticky events
        logic [TCW_EVT_W-1:0] mask;     // Interrupt mask
        logic                 pin_prev; // Pin one cycle ago
        logic                 wdt_rst;  // Reset request
        logic                 irq;      // Interrupt level
        logic                 ack;      // Bus answer
        logic [7:0]           rdata;    // Read data
    } tcw_top_s;

    // Current and next state
    tcw_top_s   s_q;
    tcw_top_s   s_d;

    // Timebase and prescaler wires
    logic       instr_tick;   // One per instruction cycle
    logic       half_tick;    // One per two sub-oscillator periods
    logic       bus_req;      // New bus access this cycle
    logic       wr_lane;      // Write with low byte enabled
    logic       wr_value;     // Write to counter value
    logic       rise;         // Pin rising edge
    logic       fall;         // Pin falling edge
    logic       cnt_event;    // Counter source event
    logic       cnt_tick;     // Counter increment
    logic       wdt_tick;     // Watchdog increment
    logic       wdt_restart;  // Clear or sleep executed
    logic       overflow;     // Counter wraps
    logic       timeout;      // Watchdog wraps
    logic       awake_ctl;    // Enable may change
    logic [7:0] cnt_pre;      // Counter prescaler count
    logic [7:0] wdt_pre;      // Watchdog prescaler count

    //------------------------------------------------------------------
    // Timebases
    //------------------------------------------------------------------
    // Instruction cycle enable
    tcw_divider #(.DIV(INSTR_CLKS)) u_instr (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_o (instr_tick)
    );

    // Half sub-oscillator enable, runs in every mode  // see RULE9
    tcw_divider #(.DIV(HALF_SUB_CLKS)) u_sub (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_o (half_tick)
    );

    //------------------------------------------------------------------
    // Event decode
    //------------------------------------------------------------------
    assign bus_req  = wb_cyc_i & wb_stb_i & ~s_q.ack;
    assign wr_lane  = bus_req & wb_we_i & wb_sel_i[0];
    assign wr_value = wr_lane & (wb_adr_i == TCW_ADR_VALUE);
    // Pin edges against last sample
    assign rise     = counter_pin_i & ~s_q.pin_prev;
    assign fall     = ~counter_pin_i & s_q.pin_prev;

    // Source choice; instruction clock stops in sleep  // see RULE6
    assign cnt_event = s_q.ctrl[TCW_CTL_SRC_BIT]
                     ? (s_q.ctrl[TCW_CTL_EDGE_BIT] ? fall : rise) // see RULE15
                     : (instr_tick & (cpu_mode_i != TCW_SLEEP));

    // Either instruction restarts the watchdog
    assign wdt_restart = wdt_clear_i | sleep_exec_i;
    assign awake_ctl   = (cpu_mode_i == TCW_NORMAL) |
                         (cpu_mode_i == TCW_GREEN);

    //------------------------------------------------------------------
    // Prescalers
    //------------------------------------------------------------------
    // Counter prescaler, bypassed when unassigned  // see RULE1, RULE13
    tcw_prescaler u_cnt_pre (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .clear_i  (wr_value),                      // see RULE3
        .inc_i    (cnt_event),
        .code_i   (s_q.ctrl[TCW_RATE_MSB:0]),      // see RULE2
        .dbl_i    (1'b1),
        .bypass_i (~s_q.ctrl[TCW_CTL_PRESCALER_ASSIGN_ENABLE_BIT]),   // see RULE7
        .tick_o   (cnt_tick),
        .count_o  (cnt_pre)
    );

    // Watchdog prescaler on half sub ticks  // see RULE1, RULE14
    tcw_prescaler u_wdt_pre (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .clear_i  (wdt_restart),                   // see RULE4
        .inc_i    (half_tick),
        .code_i   (s_q.wdog[TCW_RATE_MSB:0]),      // see RULE2
        .dbl_i    (1'b0),
        .bypass_i (1'b0),
        .tick_o   (wdt_tick),
        .count_o  (wdt_pre)
    );

    // Wraps; a value write or restart cancels the step
    assign overflow = cnt_tick & ~wr_value &
                      (s_q.value == TCW_CNT_MAX);              // see RULE17
    assign timeout  = wdt_tick & ~wdt_restart &
                      (s_q.wdt_cnt == TCW_CNT_MAX);            // see RULE12

    //------------------------------------------------------------------
    // Next state
    //------------------------------------------------------------------
    always_comb begin
        s_d          = s_q;
        // Edge memory and bus answer
        s_d.pin_prev = counter_pin_i;
        s_d.ack      = bus_req;

        // Counter value: a write beats a count  // see RULE5
        if (wr_value) begin
            s_d.value = wb_dat_i[7:0];
        end else if (cnt_tick) begin
            s_d.value = s_q.value + 8'h01;        // see RULE7, RULE8
        end

        // Watchdog count restarts with its prescaler  // see RULE18
        if (wdt_restart) begin
            s_d.wdt_cnt = TCW_CNT_ZERO;
        end else if (wdt_tick) begin
            s_d.wdt_cnt = s_q.wdt_cnt + 8'h01;    // see RULE9
        end

        // Register writes
        if (wr_lane) begin
            case (wb_adr_i)
                TCW_ADR_CTRL: begin
                    s_d.ctrl = wb_dat_i[TCW_CTRL_W-1:0];
                end
                TCW_ADR_WDOG: begin
                    s_d.wdog[TCW_RATE_MSB:0] = wb_dat_i[TCW_RATE_MSB:0];
                    // Enable only while the core runs  // see RULE11
                    if (awake_ctl) begin
                        s_d.wdog[TCW_WD_EN_BIT] = wb_dat_i[TCW_WD_EN_BIT];
                    end
                end
                TCW_ADR_STATUS: begin
                    s_d.status = s_q.status & ~wb_dat_i[TCW_EVT_W-1:0];
                end
                TCW_ADR_MASK: begin
                    s_d.mask = wb_dat_i[TCW_EVT_W-1:0];
                end
                default: begin
                    s_d.rdata = s_q.rdata; // Value and unmapped
                end
            endcase
        end

        // Events set after the clear so set wins
        if (overflow) begin
            s_d.status[TCW_ST_OVF_BIT] = 1'b1;
        end
        if (timeout & s_q.wdog[TCW_WD_EN_BIT]) begin
            s_d.status[TCW_ST_WDT_BIT] = 1'b1;
        end

        // Device reset unless sleeping  // see RULE10
        s_d.wdt_rst = timeout & s_q.wdog[TCW_WD_EN_BIT] &
                      (cpu_mode_i != TCW_SLEEP);

        // Interrupt from updated flags
        s_d.irq = |(s_d.status & s_d.mask);

        // Read data, unmapped reads as zero
        case (wb_adr_i)
            TCW_ADR_VALUE:  s_d.rdata = s_q.value;
            TCW_ADR_CTRL:   s_d.rdata = 8'(s_q.ctrl);
            TCW_ADR_WDOG:   s_d.rdata = 8'(s_q.wdog);
            TCW_ADR_STATUS: s_d.rdata = 8'(s_q.status);
            TCW_ADR_MASK:   s_d.rdata = 8'(s_q.mask);
            default:        s_d.rdata = 8'h00;
        endcase
    end

    //------------------------------------------------------------------
    // State register
    //------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q      <= '0;
            s_q.ctrl <= TCW_CTRL_RESET;
            s_q.wdog <= TCW_WDOG_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from registers
    assign wb_dat_o    = {24'h000000, s_q.rdata};
    assign wb_ack_o    = s_q.ack;
    assign irq_o       = s_q.irq;
    assign wdt_reset_o = s_q.wdt_rst;

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Prescaler clears and restarts
    pre_clear_value_a: assert property ( // see RULE3
        wr_value |=> (cnt_pre == TCW_CNT_ZERO))
        else $error("counter prescaler not cleared by value write");

    wdt_restart_a: assert property ( // see RULE4
        wdt_restart |=> (wdt_pre == TCW_CNT_ZERO) &&
                        (s_q.wdt_cnt == TCW_CNT_ZERO) && !wdt_reset_o)
        else $error("watchdog not restarted");

    // Counter value steps
    value_write_a: assert property ( // see RULE5
        wr_value |=> (s_q.value == $past(wb_dat_i[7:0])))
        else $error("counter value write lost");

    internal_step_a: assert property ( // see RULE7
        (!s_q.ctrl[TCW_CTL_SRC_BIT] && !s_q.ctrl[TCW_CTL_PRESCALER_ASSIGN_ENABLE_BIT] &&
         instr_tick && cpu_mode_i != TCW_SLEEP && !wr_value)
        |=> (s_q.value == 8'($past(s_q.value) + 8'h01)))
        else $error("counter missed instruction step");

    pin_edge_a: assert property ( // see RULE8
        (s_q.ctrl[TCW_CTL_SRC_BIT] && !s_q.ctrl[TCW_CTL_PRESCALER_ASSIGN_ENABLE_BIT] &&
         !wr_value && (s_q.ctrl[TCW_CTL_EDGE_BIT] ? fall : rise))
        |=> (s_q.value == 8'($past(s_q.value) + 8'h01)))
        else $error("counter missed pin edge");

    cnt_ratio_a: assert property ( // see RULE13
        (cnt_tick && s_q.ctrl[TCW_CTL_PRESCALER_ASSIGN_ENABLE_BIT] && !wr_value) |=>
        ((cnt_pre & tcw_ratio_mask($past(s_q.ctrl[TCW_RATE_MSB:0]),
                                   1'b1)) == TCW_CNT_ZERO))
        else $error("counter ratio wrong");

    wrap_flag_a: assert property ( // see RULE17
        overflow |=> (s_q.value == TCW_CNT_ZERO) &&
                     s_q.status[TCW_ST_OVF_BIT])
        else $error("overflow not flagged");

    // Watchdog time-out effects
    timeout_reset_a: assert property ( // see RULE10
        (timeout && s_q.wdog[TCW_WD_EN_BIT] && cpu_mode_i != TCW_SLEEP)
        |=> wdt_reset_o ##1 !wdt_reset_o)
        else $error("watchdog reset pulse wrong");

    enable_guard_a: assert property ( // see RULE11
        !awake_ctl |=> $stable(s_q.wdog[TCW_WD_EN_BIT]))
        else $error("watchdog enable changed while idle");

    no_false_reset_a: assert property ( // see RULE12
        wdt_reset_o |-> $past(s_q.wdt_cnt) == TCW_CNT_MAX)
        else $error("reset without full watchdog count");

    // Counter value moves only by write or step
    value_hold_a: assert property ( // see RULE5
        (!wr_value && !cnt_tick) |=> $stable(s_q.value))
        else $error("counter value moved without cause");

    // Reset needs an enabled, awake watchdog
    wdt_off_a: assert property ( // see RULE10
        !s_q.wdog[TCW_WD_EN_BIT] |=> !wdt_reset_o)
        else $error("reset from disabled watchdog");

    sleep_quiet_a: assert property ( // see RULE10
        (cpu_mode_i == TCW_SLEEP) |=> !wdt_reset_o)
        else $error("reset while sleeping");

    // Sticky overflow flag clears on a written one
    ovf_clear_a: assert property ( // see RULE17
        (wr_lane && wb_adr_i == TCW_ADR_STATUS && !overflow &&
         wb_dat_i[TCW_ST_OVF_BIT]) |=> !s_q.status[TCW_ST_OVF_BIT])
        else $error("overflow flag not cleared");

    // Bus answers each taken request once
    ack_pulse_a: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    // Main scenarios reached
    ovf_seen_c: cover property (overflow);
    wdt_reset_c: cover property (wdt_reset_o);
    irq_seen_c: cover property (irq_o && wb_ack_o);
    pin_count_c: cover property (s_q.ctrl[TCW_CTL_SRC_BIT] && cnt_tick);
    sleep_flag_c: cover property (timeout && cpu_mode_i == TCW_SLEEP);

endmodule

/* File: bench/tcw_top_test.sv */
// Purpose : Self-checking bench for the tick counter and watchdog
// Assumes : Half sub-oscillator tick shortened to 4 clocks
// Notes   : Prints only mismatches and the verdict
`timescale 1ns/100ps
module tcw_top_test;
    import tcw_pkg::*;
    //------------------------------------------------------------------
    // Stimulus and observed signals
    //------------------------------------------------------------------
    localparam int HS = 4;               // Clocks per half sub tick
    logic        clk_i         = 1'b0;   // System clock
    logic        rst_i         = 1'b1;   // Synchronous reset
    logic        wb_cyc_i      = 1'b0;   // Bus request
    logic        wb_stb_i      = 1'b0;
    logic        wb_we_i       = 1'b0;
    logic [7:0]  wb_adr_i      = 8'h00;
    logic [3:0]  wb_sel_i      = 4'h0;
    logic [31:0] wb_dat_i      = 32'h00000000;
    logic [31:0] wb_dat_o;               // Bus answer
    logic        wb_ack_o;
    logic        counter_pin_i = 1'b0;   // External count pin
    tcw_mode_e   cpu_mode_i    = TCW_NORMAL;
    logic        wdt_clear_i   = 1'b0;   // Core strobes
    logic        sleep_exec_i  = 1'b0;
    logic        irq_o;                  // Results
    logic        wdt_reset_o;
    int          miscompares   = 0;      // Failed comparisons
    int          checked       = 0;      // All comparisons
    int          cycle         = 0;      // Free clock count
    int          ack_cyc;                // Cycle of last bus answer
    logic [31:0] q1;
    logic [31:0] q2;
    int          n;

    tcw_top #(.INSTR_CLKS(2), .HALF_SUB_CLKS(HS)) DUT (
        .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .counter_pin_i,
        .cpu_mode_i, .wdt_clear_i, .sleep_exec_i, .irq_o, .wdt_reset_o
    );

    // 100 MHz clock and a cycle counter for interval checks
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) cycle <= cycle + 1;

    //------------------------------------------------------------------
    // Tasks
    //------------------------------------------------------------------
    // Verdict and end of run
    task automatic complete_run();
        if (miscompares == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Range compare; exact when lo equals hi
    task automatic chk_in(input logic [31:0] got, lo, hi);
        checked++;
        if (!(got >= lo && got <= hi) || $isunknown(got)) begin
            miscompares++;
            $display("unexpected at %0t: got %0h exp %0h..%0h",
                     $time, got, lo, hi);
        end
    endtask

    // One classic bus cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] a, d,
                      output logic [31:0] q);
        int k;
        k = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        if (k >= 20) begin
            miscompares++;
            complete_run();
        end
        q = wb_dat_o;
        ack_cyc = cycle;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    // Read and compare the whole word, upper bits must be zero
    task automatic rd(input logic [7:0] a, e);
        logic [31:0] q;
        wb(1'b0, a, 8'h00, q);
        chk_in(q, {24'h000000, e}, {24'h000000, e});
    endtask

    // Pin level held longer than an instruction cycle
    task automatic pin_set(input logic v);
        counter_pin_i <= v;
        repeat (4) @(posedge clk_i);
    endtask

    task automatic pulse();
        pin_set(1'b1);
        pin_set(1'b0);
    endtask

    // One-cycle clear or sleep strobe
    task automatic kick(input logic slp);
        wdt_clear_i  <= ~slp;
        sleep_exec_i <= slp;
        @(posedge clk_i);
        wdt_clear_i  <= 1'b0;
        sleep_exec_i <= 1'b0;
    endtask

    // Expect no reset pulse for c cycles
    task automatic quiet(input int c);
        int hits;
        hits = 0;
        repeat (c) begin
            @(posedge clk_i);
            if (wdt_reset_o !== 1'b0) hits++;
        end
        chk_in(hits, 0, 0);
    endtask

    //------------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(TCW_ADR_CTRL, 8'h3F);
        rd(TCW_ADR_WDOG, 8'h00);
        rd(TCW_ADR_VALUE, 8'h00);
        rd(TCW_ADR_STATUS, 8'h00);
        wr(8'h14, 8'hFF);
        rd(8'h14, 8'h00);
        // Edge select: the first move is ignored, the second counts
        for (int e = 0; e < 2; e++) begin
            pin_set(~e[0]);
            wr(TCW_ADR_CTRL, {3'b001, e[0], 4'h0});
            wr(TCW_ADR_VALUE, 8'h00);
            pin_set(e[0]);
            rd(TCW_ADR_VALUE, 8'h00);
            pin_set(~e[0]);
            rd(TCW_ADR_VALUE, 8'h01);
        end
        // Every counter ratio, rising edge, prescaler assigned
        for (int r = 0; r < 8; r++) begin
            wr(TCW_ADR_CTRL, 8'h28 | 8'(r));
            wr(TCW_ADR_VALUE, 8'h00);
            repeat ((2 << r) - 1) pulse();
            rd(TCW_ADR_VALUE, 8'h00);
            pulse();
            rd(TCW_ADR_VALUE, 8'h01);
        end
        // A value write drops the half-filled prescaler
        wr(TCW_ADR_CTRL, 8'h28);
        pulse();
        wr(TCW_ADR_VALUE, 8'h00);
        pulse();
        rd(TCW_ADR_VALUE, 8'h00);
        // Wrap, sticky flag, mask and clear
        wr(TCW_ADR_CTRL, 8'h20);
        wr(TCW_ADR_VALUE, 8'hFF);
        pulse();
        rd(TCW_ADR_VALUE, 8'h00);
        rd(TCW_ADR_STATUS, 8'h01);
        chk_in(irq_o, 0, 0);
        wr(TCW_ADR_MASK, 8'h01);
        chk_in(irq_o, 1, 1);
        wr(TCW_ADR_STATUS, 8'h01);
        rd(TCW_ADR_STATUS, 8'h00);
        chk_in(irq_o, 0, 0);
        // Internal source: one count per two clocks, none in sleep
        wr(TCW_ADR_CTRL, 8'h00);
        for (int s = 0; s < 2; s++) begin
            cpu_mode_i <= s ? TCW_SLEEP : TCW_NORMAL;
            wb(1'b0, TCW_ADR_VALUE, 8'h00, q1);
            n = ack_cyc;
            repeat (30) @(posedge clk_i);
            wb(1'b0, TCW_ADR_VALUE, 8'h00, q2);
            n = s ? 0 : ack_cyc - n;
            q2 = 2 * 32'(q2[7:0] - q1[7:0]);
            chk_in(q2, n - (n > 0), n + (n > 0));
        end
        wr(TCW_ADR_CTRL, 8'h20); // Counter parked on idle pin
        // Enable bit refused outside normal and green
        cpu_mode_i <= TCW_IDLE;
        wr(TCW_ADR_WDOG, 8'h0B);
        rd(TCW_ADR_WDOG, 8'h03);
        cpu_mode_i <= TCW_NORMAL;
        wr(TCW_ADR_WDOG, 8'h00);
        kick(1'b0);
        quiet(1100);
        rd(TCW_ADR_STATUS, 8'h00);
        // Time-out periods; a late clear or sleep restarts the count
        for (int r = 0; r < 3; r++) begin
            wr(TCW_ADR_WDOG, 8'h08 | 8'(r));
            kick(1'b0);
            quiet(500);
            kick(r == 1);
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (wdt_reset_o !== 1'b1 && n < 5000);
            chk_in(n, (256 << r) * HS - 8, (256 << r) * HS + 8);
            if (wdt_reset_o !== 1'b1) complete_run();
            rd(TCW_ADR_STATUS, 8'h02);
            wr(TCW_ADR_STATUS, 8'h02);
        end
        // Sleeping: count goes on, flag only, no reset
        cpu_mode_i <= TCW_GREEN;
        wr(TCW_ADR_WDOG, 8'h08);
        cpu_mode_i <= TCW_SLEEP;
        kick(1'b0);
        quiet(1100);
        rd(TCW_ADR_STATUS, 8'h02);
        complete_run();
    end
endmodule
